// ### src/wpsc_pkg.sv
// shared constants for the word program sequencer and its host
// assumes both ends run on one 20 MHz clock
`default_nettype none
package wpsc_pkg;
  // command codes on the low data byte
  localparam logic [7:0] CMD_SETUP  = 8'h41;
  localparam logic [7:0] CMD_ARRAY  = 8'hFF;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR  = 8'h50;
  // status byte fields
  localparam int READY_POS  = 7;
  localparam int FAIL_POS   = 4;
  localparam int SUPPLY_POS = 3;
  localparam int LOCK_POS   = 1;
  // timing
  localparam int CLK_NS       = 50;
  localparam int PROG_TIME_NS = 2000;
  localparam int PROG_CYCLES  = (PROG_TIME_NS + CLK_NS - 1) / CLK_NS;
  // host register byte offsets
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_ADDR  = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STAT  = 8'h0C;
  localparam logic [7:0] REG_IRQ   = 8'h10;
  localparam logic [7:0] REG_MASK  = 8'h14;
  // control fields
  localparam int CHECK_EACH_POS = 3;
  localparam logic [2:0] OP_NONE  = 3'h0;
  localparam logic [2:0] OP_PROG  = 3'h1;
  localparam logic [2:0] OP_ARRAY = 3'h2;
  localparam logic [2:0] OP_CLEAR = 3'h3;
  localparam logic [2:0] OP_READ  = 3'h4;
  localparam logic [2:0] OP_CHECK = 3'h5;
  // interrupt bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR  = 1;
  localparam int IRQ_REF  = 2;
  localparam int IRQ_W    = 3;
endpackage
`default_nettype wire

// ### src/wpsc_bus_if.sv
// command bus between host controller and flash sequencer
// assumes both ends share sys_clk; wr and rd are one-cycle strobes
`default_nettype none
interface wpsc_bus_if #(parameter int AW = 6);
  logic [AW-1:0] addr;
  logic [15:0]   wdata;
  logic          wr;
  logic          rd;
  logic [15:0]   rdata;
  logic          rvalid;
  modport host (output addr, wdata, wr, rd, input rdata, rvalid);
  modport dev  (input addr, wdata, wr, rd, output rdata, rvalid);
endinterface
`default_nettype wire

// ### src/wpsc_flash_dev.sv
// flash side: command decode, program engine, sticky status byte
// assumes the host keeps the two-write program order itself
`default_nettype none
module wpsc_flash_dev #(
  parameter int AW       = 6,
  parameter int BLK_W    = 2,
  parameter int PROG_CYC = wpsc_pkg::PROG_CYCLES
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  // command bus
  wpsc_bus_if.dev               bus,
  // environment
  input  wire logic             vpp_ok,
  input  wire logic [(1<<BLK_W)-1:0] lock_mask,
  output logic                  ready
);
  localparam int DEPTH = 1 << AW;

  typedef enum logic [1:0] {
    WPSC_IDLE = 2'b00,
    WPSC_DATA = 2'b01,
    WPSC_BUSY = 2'b10
  } wpsc_dstate_type;

  wpsc_dstate_type state, next_state;
  logic            mode_stat, next_mode_stat;
  logic            sr_fail, next_sr_fail;
  logic            sr_supply, next_sr_supply;
  logic            sr_lock, next_sr_lock;
  logic [15:0]     cnt, next_cnt;
  logic [AW-1:0]   tgt, next_tgt;
  logic [15:0]     word, next_word;
  logic [15:0]     rd_q, next_rd_q;
  logic            rv_q, next_rv_q;
  logic            rdy_q, next_rdy_q;
  logic [15:0]     mem [DEPTH];
  logic [15:0]     next_mem [DEPTH];
  logic [7:0]      status_byte;
  logic [15:0]     merged;

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    status_byte = 8'h00;
    status_byte[wpsc_pkg::READY_POS]  = (state != WPSC_BUSY); // [R3]
    status_byte[wpsc_pkg::FAIL_POS]   = sr_fail;
    status_byte[wpsc_pkg::SUPPLY_POS] = sr_supply;
    status_byte[wpsc_pkg::LOCK_POS]   = sr_lock;
    merged = mem[tgt] & word;
    next_state = state;
    next_mode_stat = mode_stat;
    next_sr_fail = sr_fail;
    next_sr_supply = sr_supply;
    next_sr_lock = sr_lock;
    next_cnt = cnt;
    next_tgt = tgt;
    next_word = word;
    next_mem = mem;
    next_rv_q = bus.rd;
    next_rd_q = rd_q;
    if (bus.rd)
    begin
      next_rd_q = mode_stat ? {8'h00, status_byte} : mem[bus.addr]; // [R3]
    end
    unique case (state)
      WPSC_IDLE:
      begin
        if (bus.wr)
        begin
          case (bus.wdata[7:0])
            wpsc_pkg::CMD_SETUP:
            begin
              next_state = WPSC_DATA;
              next_tgt = bus.addr;
            end
            wpsc_pkg::CMD_STATUS: next_mode_stat = 1'b1;
            wpsc_pkg::CMD_ARRAY:  next_mode_stat = 1'b0;
            wpsc_pkg::CMD_CLEAR:
            begin
              // the only path that drops the error bits [R10]
              next_sr_fail = 1'b0;
              next_sr_supply = 1'b0;
              next_sr_lock = 1'b0;
            end
            default: next_state = state;
          endcase
        end
      end
      WPSC_DATA:
      begin
        if (bus.wr)
        begin
          next_mode_stat = 1'b1; // [R3]
          next_state = WPSC_IDLE;
          next_tgt = bus.addr;
          next_word = bus.wdata;
          if (sr_supply)
          begin
            next_state = WPSC_IDLE; // refused while flagged [R7]
          end
          else if (!vpp_ok)
          begin
            next_sr_supply = 1'b1; // [R7]
          end
          else if (lock_mask[bus.addr[AW-1 -: BLK_W]])
          begin
            next_sr_lock = 1'b1; // [R9]
          end
          else
          begin
            next_state = WPSC_BUSY;
            next_cnt = 16'(PROG_CYC - 1);
          end
        end
      end
      WPSC_BUSY:
      begin
        // commands arriving while busy are dropped
        if (cnt == 16'h0000)
        begin
          next_state = WPSC_IDLE;
          next_mem[tgt] = merged;
          // bits can only go 1 to 0, so a 1 over a 0 fails
          if (merged != word)
          begin
            next_sr_fail = 1'b1; // [R8]
          end
        end
        else
        begin
          next_cnt = cnt - 16'h0001;
        end
      end
      default: next_state = WPSC_IDLE;
    endcase
    next_rdy_q = (next_state != WPSC_BUSY);
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= WPSC_IDLE;
      mode_stat <= 1'b0;
      sr_fail <= 1'b0;
      sr_supply <= 1'b0;
      sr_lock <= 1'b0;
      cnt <= 16'h0000;
      tgt <= '0;
      word <= 16'hFFFF;
      rd_q <= 16'h0000;
      rv_q <= 1'b0;
      rdy_q <= 1'b1;
    end
    else
    begin
      state <= next_state;
      mode_stat <= next_mode_stat;
      sr_fail <= next_sr_fail;
      sr_supply <= next_sr_supply;
      sr_lock <= next_sr_lock;
      cnt <= next_cnt;
      tgt <= next_tgt;
      word <= next_word;
      rd_q <= next_rd_q;
      rv_q <= next_rv_q;
      rdy_q <= next_rdy_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // array cells, erased to all ones
  for (genvar i = 0; i < DEPTH; i++)
  begin : g_cell
    always_ff @(posedge sys_clk or negedge nrst)
    begin
      if (!nrst)
      begin
        mem[i] <= 16'hFFFF;
      end
      else
      begin
        mem[i] <= next_mem[i];
      end
    end
  end

  assign bus.rdata = rd_q;
  assign bus.rvalid = rv_q;
  assign ready = rdy_q;
endmodule
`default_nettype wire

// ### src/wpsc_host_ctl.sv
// host side: wishbone registers driving flash command sequences
// assumes a classic wishbone master and the flash end on one clock
`default_nettype none
// Notes on behaviour
// (R1) setup write 0x41 at target word
// (R2) next write carries data, same address
// (R3) device answers reads with status, bit7 ready
// (R4) every word repeats both writes
// (R5) check errors per word or per series
// (R6) write 0xFF to return to array
// (R7) supply error sticks, blocks programs
// (R8) program failure sets fail bit
// (R9) locked block aborts, sets lock bit
// (R10) only clear command drops error bits
// (R11) on error, clear before anything else
// (R12) poll until ready before judging
module wpsc_host_ctl #(
  parameter int AW = 6
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq,
  // flash command bus
  wpsc_bus_if.host         bus
);
  typedef enum logic [2:0] {
    WPSC_HIDLE  = 3'b000,
    WPSC_HSETUP = 3'b001,
    WPSC_HDATA  = 3'b010,
    WPSC_HCMD   = 3'b011,
    WPSC_HPOLL  = 3'b100,
    WPSC_HWAIT  = 3'b101
  } wpsc_hstate_type;

  wpsc_hstate_type         state, next_state;
  logic [2:0]              op, next_op;
  logic                    check_each, next_check_each;
  logic [AW-1:0]           addr, next_addr;
  logic [15:0]             wdata, next_wdata;
  logic                    err, next_err;
  logic [7:0]              last_sr, next_last_sr;
  logic [15:0]             rdat, next_rdat;
  logic [wpsc_pkg::IRQ_W-1:0] irqs, next_irqs, mask, next_mask;
  logic                    ack, next_ack;
  logic [31:0]             dat, next_dat;
  logic                    irq_q, next_irq_q;
  logic                    bwr, next_bwr;
  logic                    brd, next_brd;
  logic [AW-1:0]           baddr, next_baddr;
  logic [15:0]             bdata, next_bdata;
  logic                    hit, wr_hit, rd_hit;
  logic [7:0]              reg_off;
  logic [31:0]             cur, wm;
  logic [2:0]              new_op;
  logic [wpsc_pkg::IRQ_W-1:0] ev;
  logic [7:0]              cmd;

  ////////////////////////////////////////////////////////////////////////
  // register currently addressed, for byte lane merge
  always_comb
  begin
    reg_off = {wb_adr_i[7:2], 2'b00};
    unique case (reg_off)
      wpsc_pkg::REG_CTRL:  cur = {28'h0000000, check_each, op};
      wpsc_pkg::REG_ADDR:  cur = 32'(addr);
      wpsc_pkg::REG_WDATA: cur = {16'h0000, wdata};
      wpsc_pkg::REG_STAT:  cur = {rdat, last_sr, 6'h00, err,
                                  state != WPSC_HIDLE};
      wpsc_pkg::REG_IRQ:   cur = 32'(irqs);
      wpsc_pkg::REG_MASK:  cur = 32'(mask);
      default:             cur = 32'h00000000;
    endcase
    for (int b = 0; b < 4; b++)
    begin
      wm[b*8 +: 8] = wb_sel_i[b] ? wb_dat_i[b*8 +: 8] : cur[b*8 +: 8];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    hit = wb_cyc_i & wb_stb_i;
    wr_hit = hit & wb_ack_o & wb_we_i;
    rd_hit = hit & wb_ack_o & ~wb_we_i;
    next_ack = hit & ~ack;
    next_dat = dat;
    if (hit & ~ack)
    begin
      next_dat = wb_we_i ? 32'h00000000 : cur;
    end
    next_state = state;
    next_op = op;
    next_check_each = check_each;
    next_addr = addr;
    next_wdata = wdata;
    next_err = err;
    next_last_sr = last_sr;
    next_rdat = rdat;
    next_mask = mask;
    next_bwr = 1'b0;
    next_brd = 1'b0;
    next_baddr = baddr;
    next_bdata = bdata;
    ev = '0;
    new_op = wpsc_pkg::OP_NONE;
    cmd = wpsc_pkg::CMD_ARRAY;
    if (wr_hit)
    begin
      unique case (reg_off)
        wpsc_pkg::REG_CTRL:
        begin
          new_op = wm[2:0];
          next_check_each = wm[wpsc_pkg::CHECK_EACH_POS];
        end
        wpsc_pkg::REG_ADDR:  next_addr = wm[AW-1:0];
        wpsc_pkg::REG_WDATA: next_wdata = wm[15:0];
        wpsc_pkg::REG_MASK:  next_mask = wm[wpsc_pkg::IRQ_W-1:0];
        default:             next_mask = mask;
      endcase
    end
    if (new_op != wpsc_pkg::OP_NONE)
    begin
      // a known error blocks all but the clear command [R11]
      if (state != WPSC_HIDLE ||
          (err && new_op != wpsc_pkg::OP_CLEAR))
      begin
        ev[wpsc_pkg::IRQ_REF] = 1'b1;
      end
      else
      begin
        next_op = new_op;
        if (new_op == wpsc_pkg::OP_PROG)
        begin
          next_state = WPSC_HSETUP;
        end
        else if (new_op == wpsc_pkg::OP_READ)
        begin
          next_state = WPSC_HPOLL;
        end
        else
        begin
          next_state = WPSC_HCMD;
        end
      end
    end
    unique case (op)
      wpsc_pkg::OP_CLEAR: cmd = wpsc_pkg::CMD_CLEAR;
      wpsc_pkg::OP_CHECK: cmd = wpsc_pkg::CMD_STATUS;
      default:            cmd = wpsc_pkg::CMD_ARRAY; // [R6]
    endcase
    unique case (state)
      WPSC_HIDLE: next_bwr = 1'b0;
      WPSC_HSETUP:
      begin
        // each word gets its own setup write [R4]
        next_bwr = 1'b1;
        next_baddr = addr;
        next_bdata = {8'h00, wpsc_pkg::CMD_SETUP}; // [R1]
        next_state = WPSC_HDATA;
      end
      WPSC_HDATA:
      begin
        next_bwr = 1'b1;
        next_baddr = addr; // [R2]
        next_bdata = wdata; // [R2]
        next_state = WPSC_HPOLL;
      end
      WPSC_HCMD:
      begin
        next_bwr = 1'b1;
        next_baddr = addr;
        next_bdata = {8'h00, cmd};
        if (op == wpsc_pkg::OP_CHECK)
        begin
          next_state = WPSC_HPOLL;
        end
        else
        begin
          if (op == wpsc_pkg::OP_CLEAR)
          begin
            next_err = 1'b0;
          end
          ev[wpsc_pkg::IRQ_DONE] = 1'b1;
          next_state = WPSC_HIDLE;
        end
      end
      WPSC_HPOLL:
      begin
        next_brd = 1'b1;
        next_baddr = addr;
        next_state = WPSC_HWAIT;
      end
      WPSC_HWAIT:
      begin
        if (bus.rvalid)
        begin
          if (op == wpsc_pkg::OP_READ)
          begin
            next_rdat = bus.rdata;
            ev[wpsc_pkg::IRQ_DONE] = 1'b1;
            next_state = WPSC_HIDLE;
          end
          else
          begin
            next_last_sr = bus.rdata[7:0];
            if (!bus.rdata[wpsc_pkg::READY_POS])
            begin
              next_state = WPSC_HPOLL; // [R12]
            end
            else
            begin
              ev[wpsc_pkg::IRQ_DONE] = 1'b1;
              next_state = WPSC_HIDLE;
              // per word or only on an explicit check [R5]
              if ((check_each || op == wpsc_pkg::OP_CHECK) &&
                  (bus.rdata[wpsc_pkg::SUPPLY_POS] ||
                   bus.rdata[wpsc_pkg::FAIL_POS] ||
                   bus.rdata[wpsc_pkg::LOCK_POS]))
              begin
                next_err = 1'b1; // [R11]
                ev[wpsc_pkg::IRQ_ERR] = 1'b1;
              end
            end
          end
        end
      end
      default: next_state = WPSC_HIDLE;
    endcase
    // read clears, but a new event in that cycle survives
    next_irqs = (rd_hit && reg_off == wpsc_pkg::REG_IRQ) ? ev : irqs | ev;
    next_irq_q = |(next_irqs & next_mask);
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= WPSC_HIDLE;
      op <= wpsc_pkg::OP_NONE;
      check_each <= 1'b1;
      addr <= '0;
      wdata <= 16'h0000;
      err <= 1'b0;
      last_sr <= 8'h00;
      rdat <= 16'h0000;
      irqs <= '0;
      mask <= '0;
      ack <= 1'b0;
      dat <= 32'h00000000;
      irq_q <= 1'b0;
      bwr <= 1'b0;
      brd <= 1'b0;
      baddr <= '0;
      bdata <= 16'h0000;
    end
    else
    begin
      state <= next_state;
      op <= next_op;
      check_each <= next_check_each;
      addr <= next_addr;
      wdata <= next_wdata;
      err <= next_err;
      last_sr <= next_last_sr;
      rdat <= next_rdat;
      irqs <= next_irqs;
      mask <= next_mask;
      ack <= next_ack;
      dat <= next_dat;
      irq_q <= next_irq_q;
      bwr <= next_bwr;
      brd <= next_brd;
      baddr <= next_baddr;
      bdata <= next_bdata;
    end
  end

  assign wb_ack_o = ack;
  assign wb_dat_o = dat;
  assign irq = irq_q;
  assign bus.wr = bwr;
  assign bus.rd = brd;
  assign bus.addr = baddr;
  assign bus.wdata = bdata;
endmodule
`default_nettype wire

// ### test/wpsc_assertions.sv
// concurrent checks on the command bus between host controller and flash
// assumes tb_top instantiates it beside the interface; one clock domain
`default_nettype none
module wpsc_assertions #(
  parameter int AW       = 6,
  parameter int PROG_CYC = 3
) (
  // clock and reset
  input wire logic          sys_clk,
  input wire logic          nrst,
  // command bus
  input wire logic [AW-1:0] addr,
  input wire logic [15:0]   wdata,
  input wire logic          wr,
  input wire logic          rd,
  input wire logic [15:0]   rdata,
  input wire logic          rvalid
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////
  logic        setup_seen, next_setup_seen;
  logic        polling,    next_polling;
  logic        smode,      next_smode;
  logic [7:0]  sticky,     next_sticky;
  logic [15:0] poll_cnt,   next_poll_cnt;
  logic        setup;
  logic        data_wr;
  logic        cmd_wr;
  // a write right after a setup is data whatever its value
  assign setup   = wr && !setup_seen && wdata[7:0] == wpsc_pkg::CMD_SETUP;
  assign data_wr = wr && setup_seen;
  assign cmd_wr  = wr && !setup_seen;
  always_comb
  begin
    next_setup_seen = setup;
    next_polling    = polling;
    next_smode      = smode;
    next_sticky     = sticky;
    next_poll_cnt   = polling ? poll_cnt + 16'h0001 : 16'h0000;
    if (data_wr)
      next_polling = 1'b1;
    else if (rvalid && rdata[wpsc_pkg::READY_POS])
      next_polling = 1'b0;
    if (data_wr || (cmd_wr && wdata[7:0] == wpsc_pkg::CMD_STATUS))
      next_smode = 1'b1;
    else if (cmd_wr && wdata[7:0] == wpsc_pkg::CMD_ARRAY)
      next_smode = 1'b0;
    if (cmd_wr && wdata[7:0] == wpsc_pkg::CMD_CLEAR)
      next_sticky = 8'h00;
    else if (rvalid && smode)
      next_sticky = sticky | (rdata[7:0] & 8'h1A);
  end
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      setup_seen <= 1'b0;
      polling    <= 1'b0;
      smode      <= 1'b0;
      sticky     <= 8'h00;
      poll_cnt   <= 16'h0000;
    end
    else
    begin
      setup_seen <= next_setup_seen;
      polling    <= next_polling;
      smode      <= next_smode;
      sticky     <= next_sticky;
      poll_cnt   <= next_poll_cnt;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_rd_answer: assert property (rd |=> rvalid)
    else $error("no read answer one cycle after rd");
  a_rvalid_cause: assert property (rvalid |-> $past(rd))
    else $error("rvalid without a preceding rd");
  a_rdata_hold: assert property ($changed(rdata) |-> rvalid)
    else $error("read data moved outside an answer");
  a_setup_data: assert property (setup |=> wr && addr == $past(addr))
    else $error("setup not followed by data write at same word");
  a_data_poll: assert property (data_wr |=> rd)
    else $error("data write not followed by a status poll");
  a_no_wr_poll: assert property (polling |-> !wr)
    else $error("write issued before ready was seen");
  a_poll_bound: assert property (polling |->
    int'(poll_cnt) < PROG_CYC + 12)
    else $error("program poll ran too long");
  a_error_sticky: assert property (rvalid && smode |->
    (rdata[7:0] & sticky) == sticky)
    else $error("error bit dropped without clear command");
  a_supply_refuse: assert property (data_wr && sticky[3] |->
    ##2 rvalid && rdata[wpsc_pkg::READY_POS])
    else $error("program started while supply error set");
endmodule
`default_nettype wire

// ### test/tb_top.sv
// word program bench: host controller and flash end joined by the bus
// assumes a short program time parameter; wishbone tasks drive all ops
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk, nrst, cyc, stb, we, vpp_ok, dev_ready, irq, ack;
  logic [7:0]  adr;
  logic [31:0] dat, dat_o;
  logic [3:0]  lock_mask;
  int          n_mismatch, check_count;
  wpsc_bus_if wpsc_bus_if_inst ();
  wpsc_flash_dev #(.PROG_CYC(3)) wpsc_flash_dev_inst (
    .sys_clk(sys_clk), .nrst(nrst), .bus(wpsc_bus_if_inst),
    .vpp_ok(vpp_ok), .lock_mask(lock_mask), .ready(dev_ready));
  wpsc_host_ctl wpsc_host_ctl_inst (
    .sys_clk(sys_clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hF),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .irq(irq), .bus(wpsc_bus_if_inst));
  wpsc_assertions #(.PROG_CYC(3)) wpsc_assertions_inst (
    .sys_clk(sys_clk), .nrst(nrst), .addr(wpsc_bus_if_inst.addr),
    .wdata(wpsc_bus_if_inst.wdata), .wr(wpsc_bus_if_inst.wr),
    .rd(wpsc_bus_if_inst.rd), .rdata(wpsc_bus_if_inst.rdata),
    .rvalid(wpsc_bus_if_inst.rvalid));
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic summarize;
    $display("counts: %0d checks, %0d mismatches", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ack and read data are taken at the rising edge, before its updates land
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (ack !== 1'b1 && n < 200);
    q = dat_o;
    if (n >= 200)
      n_mismatch++;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask
  task automatic op(input logic [5:0] a, input logic [15:0] d,
                    input logic [3:0] c);
    logic [31:0] q;
    int n;
    wreg(wpsc_pkg::REG_ADDR, {26'h0, a});
    wreg(wpsc_pkg::REG_WDATA, {16'h0, d});
    wreg(wpsc_pkg::REG_CTRL, {28'h0, c});
    n = 0;
    do
    begin
      wb(1'b0, wpsc_pkg::REG_STAT, 32'h0, q);
      n++;
    end
    while (q[0] !== 1'b0 && n < 100);
    if (n >= 100)
      n_mismatch++;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    summarize();
  end
  initial
  begin
    {nrst, cyc, stb, we, adr, dat} = '0;
    vpp_ok = 1'b1;
    lock_mask = 4'h0;
    n_mismatch = 0;
    check_count = 0;
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    rchk(wpsc_pkg::REG_MASK, 32'h7, 32'h0);
    rchk(wpsc_pkg::REG_IRQ, 32'h7, 32'h0);
    rchk(wpsc_pkg::REG_CTRL, 32'h8, 32'h8);
    wreg(8'h18, 32'hFFFFFFFF);
    rchk(8'h18, 32'hFFFFFFFF, 32'h0);
    $display("test reset done");
    op(6'h05, 16'h00A5, 4'h9);
    rchk(wpsc_pkg::REG_STAT, 32'hFF03, 32'h8000);
    chk({31'h0, dev_ready}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    rchk(wpsc_pkg::REG_IRQ, 32'h1, 32'h1);
    wreg(wpsc_pkg::REG_MASK, 32'h7);
    op(6'h05, 16'h0, 4'hA);
    op(6'h05, 16'h0, 4'hC);
    rchk(wpsc_pkg::REG_STAT, 32'hFFFF0000, 32'h00A50000);
    rchk(wpsc_pkg::REG_IRQ, 32'h6, 32'h0);
    $display("test program done");
    op(6'h05, 16'h00FF, 4'h9);
    rchk(wpsc_pkg::REG_STAT, 32'hFF02, 32'h9002);
    chk({31'h0, irq}, 32'h1);
    rchk(wpsc_pkg::REG_IRQ, 32'h2, 32'h2);
    wreg(wpsc_pkg::REG_CTRL, 32'h9);
    rchk(wpsc_pkg::REG_IRQ, 32'h4, 32'h4);
    rchk(wpsc_pkg::REG_STAT, 32'h2, 32'h2);
    op(6'h0, 16'h0, 4'hB);
    rchk(wpsc_pkg::REG_STAT, 32'h2, 32'h0);
    $display("test fail done");
    op(6'h05, 16'h005A, 4'h1);
    rchk(wpsc_pkg::REG_STAT, 32'h2, 32'h0);
    op(6'h0, 16'h0, 4'h2);
    op(6'h0, 16'h0, 4'h5);
    rchk(wpsc_pkg::REG_STAT, 32'hFF02, 32'h9002);
    op(6'h0, 16'h0, 4'hB);
    $display("test series done");
    lock_mask <= 4'h4;
    op(6'h21, 16'h0, 4'h9);
    rchk(wpsc_pkg::REG_STAT, 32'hFF02, 32'h8202);
    lock_mask <= 4'h0;
    op(6'h0, 16'h0, 4'hB);
    op(6'h0, 16'h0, 4'hA);
    op(6'h21, 16'h0, 4'hC);
    rchk(wpsc_pkg::REG_STAT, 32'hFFFF0000, 32'hFFFF0000);
    $display("test lock done");
    vpp_ok <= 1'b0;
    op(6'h06, 16'h0, 4'h1);
    vpp_ok <= 1'b1;
    op(6'h06, 16'h0, 4'h1);
    op(6'h0, 16'h0, 4'h5);
    rchk(wpsc_pkg::REG_STAT, 32'hFF02, 32'h8802);
    op(6'h0, 16'h0, 4'hB);
    op(6'h0, 16'h0, 4'hA);
    op(6'h06, 16'h0, 4'hC);
    rchk(wpsc_pkg::REG_STAT, 32'hFFFF0000, 32'hFFFF0000);
    $display("test supply done");
    summarize();
  end
endmodule
`default_nettype wire
